// file: design/mcu_exec_pkg.sv
// Constants and types shared by the instruction executor and its ALU
// Functional notes
// - Each instruction is one 13-bit word (long call and jump add a target word): opcode field plus operand fields.
// - An instruction cycle is two clocks; ordinary instructions take one.
// - A register operation writing the program counter takes two cycles.
// - Jump, call and all returns complete in one instruction cycle; long call and jump take two.
// - A conditional skip whose condition is true takes two cycles.
// - Any bit of any register can be cleared or tested, and set except in the interrupt status register.
// - I/O registers behave as general registers for every instruction except single-bit set on the interrupt status register.
// - Control register moves reach only indices 5 to 7 and 10 to 15.
// - Single-bit set has no effect on the interrupt status register.
// - Literals inside a word are 8 bits, or 10 bits for jumps.
// - Table read stores low byte, or high five bits, per select.
// - Long call and jump take target from next word; call pushes return.
// - Returns pop the stack; interrupt return enables, literal loads A.
`default_nettype none
package mcu_exec_pkg;
  // Word groups in bits 12:11
  localparam logic [1:0] GRP_REG = 2'h0;
  localparam logic [1:0] GRP_LIT = 2'h1;
  localparam logic [1:0] GRP_BIT = 2'h2;
  localparam logic [1:0] GRP_JMP = 2'h3;
  // Register group operations in bits 10:7, bit 6 selects register dest
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CTRL = 4'h1;
  localparam logic [3:0] OP_CLR  = 4'h2;
  localparam logic [3:0] OP_SUB  = 4'h3;
  localparam logic [3:0] OP_DEC  = 4'h4;
  localparam logic [3:0] OP_OR   = 4'h5;
  localparam logic [3:0] OP_AND  = 4'h6;
  localparam logic [3:0] OP_XOR  = 4'h7;
  localparam logic [3:0] OP_ADD  = 4'h8;
  localparam logic [3:0] OP_MOV  = 4'h9;
  localparam logic [3:0] OP_COM  = 4'ha;
  localparam logic [3:0] OP_INC  = 4'hb;
  localparam logic [3:0] OP_DJZ  = 4'hc;
  localparam logic [3:0] OP_RRC  = 4'hd;
  localparam logic [3:0] OP_RLC  = 4'he;
  localparam logic [3:0] OP_JZ   = 4'hf;
  // Codes in the register field of OP_MISC with bit 6 clear
  localparam logic [5:0] MISC_RET   = 6'h01;
  localparam logic [5:0] MISC_INTERRUPT_RETURN_OP  = 6'h02;
  localparam logic [5:0] MISC_ENI   = 6'h03;
  localparam logic [5:0] MISC_DISI  = 6'h04;
  localparam logic [5:0] MISC_SLEEP = 6'h05;
  localparam logic [5:0] MISC_WDTC  = 6'h06;
  localparam logic [5:0] MISC_CLRA  = 6'h07;
  localparam logic [5:0] MISC_LONG_CALL_OP = 6'h08;
  localparam logic [5:0] MISC_LONG_JUMP_OP  = 6'h09;
  // Literal group operations in bits 10:8
  localparam logic [2:0] LIT_MOV  = 3'h0;
  localparam logic [2:0] LIT_OR   = 3'h1;
  localparam logic [2:0] LIT_AND  = 3'h2;
  localparam logic [2:0] LIT_XOR  = 3'h3;
  localparam logic [2:0] LIT_LITERAL_RETURN_OP = 3'h4;
  localparam logic [2:0] LIT_SUB  = 3'h5;
  localparam logic [2:0] LIT_ADD  = 3'h6;
  // Bit group operations in bits 10:9
  localparam logic [1:0] BOP_CLEAR    = 2'h0;
  localparam logic [1:0] BOP_SET      = 2'h1;
  localparam logic [1:0] BOP_SKIP_CLR = 2'h2;
  localparam logic [1:0] BOP_SKIP_SET = 2'h3;
  // Register addresses with special meaning
  localparam logic [5:0] ADDR_PC         = 6'h02;
  localparam logic [5:0] ADDR_STATUS     = 6'h03;
  localparam logic [5:0] ADDR_TBL_LO     = 6'h09;
  localparam logic [5:0] ADDR_TBL_HI     = 6'h0a;
  localparam logic [5:0] ADDR_INT_STATUS = 6'h0f;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int TBL_SEL_BIT = 7;
  // Control register indices that exist
  localparam logic [15:0] IOC_VALID = 16'hfce0;
  localparam int STACK_DEPTH = 8;
  typedef enum logic [1:0] {
    mode_exec, mode_dead, mode_long, mode_table
  } mode_t;
endpackage : mcu_exec_pkg
`default_nettype wire

// file: design/mcu_alu.sv
// Eight-bit ALU for the instruction executor
`default_nettype none
module mcu_alu (
  // Operation select
  input  wire logic [3:0] i_op,
  // Operands
  input  wire logic [7:0] i_acc,
  input  wire logic [7:0] i_opnd,
  input  wire logic       i_carry,
  // Result and flags
  output logic      [7:0] o_result,
  output logic            o_zero,
  output logic            o_carry,
  output logic            o_dcarry
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    o_result = i_opnd;
    o_carry = i_carry;
    o_dcarry = 1'b0;
    case (i_op)
      mcu_exec_pkg::OP_ADD: begin
        sum = {1'b0, i_acc} + {1'b0, i_opnd};
        nib = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]};
        o_result = sum[7:0];
        o_carry = sum[8];
        o_dcarry = nib[4];
      end
      mcu_exec_pkg::OP_SUB: begin
        // Carry reads as no-borrow
        sum = {1'b0, i_opnd} - {1'b0, i_acc};
        nib = {1'b0, i_opnd[3:0]} - {1'b0, i_acc[3:0]};
        o_result = sum[7:0];
        o_carry = ~sum[8];
        o_dcarry = ~nib[4];
      end
      mcu_exec_pkg::OP_DEC, mcu_exec_pkg::OP_DJZ: o_result = i_opnd - 8'h01;
      mcu_exec_pkg::OP_INC, mcu_exec_pkg::OP_JZ:  o_result = i_opnd + 8'h01;
      mcu_exec_pkg::OP_OR:  o_result = i_acc | i_opnd;
      mcu_exec_pkg::OP_AND: o_result = i_acc & i_opnd;
      mcu_exec_pkg::OP_XOR: o_result = i_acc ^ i_opnd;
      mcu_exec_pkg::OP_COM: o_result = ~i_opnd;
      mcu_exec_pkg::OP_CLR: o_result = 8'h00;
      mcu_exec_pkg::OP_RRC: begin
        o_result = {i_carry, i_opnd[7:1]};
        o_carry = i_opnd[0];
      end
      mcu_exec_pkg::OP_RLC: begin
        o_result = {i_opnd[6:0], i_carry};
        o_carry = i_opnd[7];
      end
      default: o_result = i_opnd;
    endcase
    o_zero = (o_result == 8'h00);
  end
endmodule : mcu_alu
`default_nettype wire

// file: design/mcu_instruction_executor.sv
// Fetch, decode and execution sequencing of the 8-bit core
`default_nettype none
module mcu_instruction_executor (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // Program memory
  output logic      [12:0] o_prog_addr,
  input  wire logic [12:0] i_prog_data,
  // Wake from sleep
  input  wire logic        i_wake,
  // Core state
  output logic      [12:0] o_pc,
  output logic      [7:0]  o_acc,
  output logic             o_zero,
  output logic             o_carry,
  output logic             o_dcarry,
  output logic             o_int_enable,
  output logic             o_sleeping,
  output logic             o_wdt_clear,
  output logic             o_instr_done
);
  typedef struct packed {
    logic                   phase;
    mcu_exec_pkg::mode_t    mode;
    logic [12:0]            pc;
    logic [12:0]            prog_addr;
    logic [7:0]             acc;
    logic                   zero;
    logic                   carry;
    logic                   dcarry;
    logic                   int_en;
    logic                   sleeping;
    logic                   wdt_clear;
    logic                   done;
    logic                   long_call;
    logic                   tbl_high;
    logic [5:0]             tbl_dest;
    logic [2:0]             sp;
    logic [63:0][7:0]       regs;
    logic [15:0][7:0]       ioc;
    logic [mcu_exec_pkg::STACK_DEPTH-1:0][12:0] stack;
  } state_t;

  state_t              st;
  state_t              next_st;
  logic [12:0]         next_pc;
  logic [12:0]         fetch;
  mcu_exec_pkg::mode_t next_mode;
  logic                goto_dead;
  logic                wr_en;
  logic [5:0]          wr_addr;
  logic [7:0]          wr_data;
  logic                upd_z;
  logic                upd_c;
  logic                upd_dc;
  logic [7:0]          rv;
  logic [7:0]          bit_mask;
  logic [3:0]          alu_op;
  logic [7:0]          alu_opnd;
  logic [7:0]          alu_res;
  logic                alu_z;
  logic                alu_c;
  logic                alu_dc;
  logic [12:0]         top;
  logic [7:0]          tbl_lo_bits;
  logic [7:0]          tbl_hi_bits;
  logic                exec_now;

  // Word fields
  logic [1:0] grp;
  logic [3:0] rop;
  logic       dst;
  logic [5:0] r;
  logic [2:0] lop;
  logic [7:0] k8;
  logic [1:0] bop;
  logic [2:0] bnum;
  assign grp  = i_prog_data[12:11];
  assign rop  = i_prog_data[10:7];
  assign dst  = i_prog_data[6];
  assign r    = i_prog_data[5:0];
  assign lop  = i_prog_data[10:8];
  assign k8   = i_prog_data[7:0];
  assign bop  = i_prog_data[10:9];
  assign bnum = i_prog_data[8:6];
  assign top  = st.stack[st.sp - 3'h1];
  assign tbl_lo_bits = i_prog_data[7:0];
  assign tbl_hi_bits = {3'h0, i_prog_data[12:8]};
  assign exec_now = st.phase && (st.mode == mcu_exec_pkg::mode_exec) &&
                    !st.sleeping;
  assign bit_mask = 8'h01 << bnum;

  // Status and program counter read back like any register
  always_comb begin
    rv = st.regs[r];
    if (r == mcu_exec_pkg::ADDR_PC) begin
      rv = st.pc[7:0];
    end else if (r == mcu_exec_pkg::ADDR_STATUS) begin
      rv = 8'h00;
      rv[mcu_exec_pkg::ST_Z] = st.zero;
      rv[mcu_exec_pkg::ST_DC] = st.dcarry;
      rv[mcu_exec_pkg::ST_C] = st.carry;
    end
  end

  always_comb begin
    alu_op = rop;
    alu_opnd = rv;
    if (grp == mcu_exec_pkg::GRP_LIT) begin
      alu_opnd = k8;
      case (lop)
        mcu_exec_pkg::LIT_OR:  alu_op = mcu_exec_pkg::OP_OR;
        mcu_exec_pkg::LIT_AND: alu_op = mcu_exec_pkg::OP_AND;
        mcu_exec_pkg::LIT_XOR: alu_op = mcu_exec_pkg::OP_XOR;
        mcu_exec_pkg::LIT_SUB: alu_op = mcu_exec_pkg::OP_SUB;
        mcu_exec_pkg::LIT_ADD: alu_op = mcu_exec_pkg::OP_ADD;
        default:               alu_op = mcu_exec_pkg::OP_MOV;
      endcase
    end
  end

  mcu_alu u_alu (
    .i_op     (alu_op),
    .i_acc    (st.acc),
    .i_opnd   (alu_opnd),
    .i_carry  (st.carry),
    .o_result (alu_res),
    .o_zero   (alu_z),
    .o_carry  (alu_c),
    .o_dcarry (alu_dc)
  );

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.wdt_clear = 1'b0;
    next_st.phase = ~st.phase;
    next_pc = st.pc + 13'h0001;
    fetch = 13'h0000;
    next_mode = mcu_exec_pkg::mode_exec;
    goto_dead = 1'b0;
    wr_en = 1'b0;
    wr_addr = r;
    wr_data = alu_res;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    if (st.phase && st.sleeping) begin
      // Fetch address is held so the wake resumes at the next word
      if (i_wake) begin
        next_st.sleeping = 1'b0;
      end
    end else if (st.phase) begin
      case (st.mode)
        mcu_exec_pkg::mode_exec: begin
          case (grp)
            mcu_exec_pkg::GRP_REG: begin
              if (rop >= mcu_exec_pkg::OP_SUB) begin
                if (dst) begin
                  wr_en = 1'b1;
                end else begin
                  next_st.acc = alu_res;
                end
              end
              case (rop)
                mcu_exec_pkg::OP_MISC: begin
                  if (dst) begin
                    wr_en = 1'b1;
                    wr_data = st.acc;
                  end else begin
                    case (r)
                      mcu_exec_pkg::MISC_RET, mcu_exec_pkg::MISC_INTERRUPT_RETURN_OP: begin
                        next_pc = top;
                        next_st.sp = st.sp - 3'h1;
                        if (r == mcu_exec_pkg::MISC_INTERRUPT_RETURN_OP) begin
                          next_st.int_en = 1'b1;
                        end
                      end
                      mcu_exec_pkg::MISC_ENI:  next_st.int_en = 1'b1;
                      mcu_exec_pkg::MISC_DISI: next_st.int_en = 1'b0;
                      mcu_exec_pkg::MISC_SLEEP: begin
                        next_st.sleeping = 1'b1;
                        next_st.wdt_clear = 1'b1;
                      end
                      mcu_exec_pkg::MISC_WDTC: next_st.wdt_clear = 1'b1;
                      mcu_exec_pkg::MISC_CLRA: begin
                        next_st.acc = 8'h00;
                        next_st.zero = 1'b1;
                      end
                      mcu_exec_pkg::MISC_LONG_CALL_OP, mcu_exec_pkg::MISC_LONG_JUMP_OP: begin
                        next_mode = mcu_exec_pkg::mode_long;
                        next_st.long_call = (r == mcu_exec_pkg::MISC_LONG_CALL_OP);
                        next_pc = st.pc;
                        fetch = st.pc + 13'h0001;
                      end
                      default: next_st.int_en = st.int_en;
                    endcase
                  end
                end
                mcu_exec_pkg::OP_CTRL: begin
                  // Other indices are ignored, A keeps its value
                  if (r[5:4] == 2'h0 && mcu_exec_pkg::IOC_VALID[r[3:0]]) begin
                    if (dst) begin
                      next_st.ioc[r[3:0]] = st.acc;
                    end else begin
                      next_st.acc = st.ioc[r[3:0]];
                    end
                  end
                end
                mcu_exec_pkg::OP_CLR: begin
                  if (dst) begin
                    wr_en = 1'b1;
                    upd_z = 1'b1;
                  end else begin
                    // Program port is shared, so the table word costs a cycle
                    next_mode = mcu_exec_pkg::mode_table;
                    next_st.tbl_dest = r;
                    next_st.tbl_high = st.regs[mcu_exec_pkg::ADDR_TBL_HI]
                                       [mcu_exec_pkg::TBL_SEL_BIT];
                    fetch = {st.regs[mcu_exec_pkg::ADDR_TBL_HI][4:0],
                             st.regs[mcu_exec_pkg::ADDR_TBL_LO]};
                  end
                end
                mcu_exec_pkg::OP_SUB, mcu_exec_pkg::OP_ADD: begin
                  upd_z = 1'b1;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                end
                mcu_exec_pkg::OP_RRC, mcu_exec_pkg::OP_RLC: begin
                  upd_c = 1'b1;
                end
                mcu_exec_pkg::OP_DJZ, mcu_exec_pkg::OP_JZ: begin
                  if (alu_z) begin
                    next_pc = st.pc + 13'h0002;
                    goto_dead = 1'b1;
                  end
                end
                default: upd_z = 1'b1;
              endcase
            end
            mcu_exec_pkg::GRP_LIT: begin
              case (lop)
                mcu_exec_pkg::LIT_MOV: next_st.acc = k8;
                mcu_exec_pkg::LIT_LITERAL_RETURN_OP: begin
                  next_st.acc = k8;
                  next_pc = top;
                  next_st.sp = st.sp - 3'h1;
                end
                mcu_exec_pkg::LIT_SUB, mcu_exec_pkg::LIT_ADD: begin
                  next_st.acc = alu_res;
                  upd_z = 1'b1;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                end
                mcu_exec_pkg::LIT_OR, mcu_exec_pkg::LIT_AND,
                mcu_exec_pkg::LIT_XOR: begin
                  next_st.acc = alu_res;
                  upd_z = 1'b1;
                end
                default: next_st.acc = st.acc;
              endcase
            end
            mcu_exec_pkg::GRP_BIT: begin
              case (bop)
                mcu_exec_pkg::BOP_CLEAR: begin
                  wr_en = 1'b1;
                  wr_data = rv & ~bit_mask;
                end
                mcu_exec_pkg::BOP_SET: begin
                  wr_en = (r != mcu_exec_pkg::ADDR_INT_STATUS);
                  wr_data = rv | bit_mask;
                end
                mcu_exec_pkg::BOP_SKIP_CLR, mcu_exec_pkg::BOP_SKIP_SET: begin
                  if (rv[bnum] == (bop == mcu_exec_pkg::BOP_SKIP_SET)) begin
                    next_pc = st.pc + 13'h0002;
                    goto_dead = 1'b1;
                  end
                end
                default: wr_en = 1'b0;
              endcase
            end
            default: begin
              next_pc = {st.pc[12:10], i_prog_data[9:0]};
              if (i_prog_data[10]) begin
                next_st.stack[st.sp] = st.pc + 13'h0001;
                next_st.sp = st.sp + 3'h1;
              end
            end
          endcase
        end
        mcu_exec_pkg::mode_long: begin
          next_pc = i_prog_data;
          if (st.long_call) begin
            next_st.stack[st.sp] = st.pc + 13'h0002;
            next_st.sp = st.sp + 3'h1;
          end
        end
        mcu_exec_pkg::mode_table: begin
          next_pc = st.pc;
          wr_en = 1'b1;
          wr_addr = st.tbl_dest;
          wr_data = st.tbl_high ? tbl_hi_bits : tbl_lo_bits;
        end
        default: next_pc = st.pc;
      endcase
      if (wr_en) begin
        case (wr_addr)
          mcu_exec_pkg::ADDR_PC: begin
            next_pc = {st.pc[12:8], wr_data};
            goto_dead = 1'b1;
          end
          mcu_exec_pkg::ADDR_STATUS: begin
            next_st.zero = wr_data[mcu_exec_pkg::ST_Z];
            next_st.dcarry = wr_data[mcu_exec_pkg::ST_DC];
            next_st.carry = wr_data[mcu_exec_pkg::ST_C];
          end
          default: next_st.regs[wr_addr] = wr_data;
        endcase
      end
      // Flag results take priority over a direct status write
      if (upd_z) begin
        next_st.zero = alu_z;
      end
      if (upd_c) begin
        next_st.carry = alu_c;
      end
      if (upd_dc) begin
        next_st.dcarry = alu_dc;
      end
      next_st.pc = next_pc;
      next_st.mode = goto_dead ? mcu_exec_pkg::mode_dead : next_mode;
      next_st.prog_addr = (next_st.mode == mcu_exec_pkg::mode_long ||
                           next_st.mode == mcu_exec_pkg::mode_table) ?
                          fetch : next_pc;
      next_st.done = (next_st.mode == mcu_exec_pkg::mode_exec);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_prog_addr  = st.prog_addr;
  assign o_pc         = st.pc;
  assign o_acc        = st.acc;
  assign o_zero       = st.zero;
  assign o_carry      = st.carry;
  assign o_dcarry     = st.dcarry;
  assign o_int_enable = st.int_en;
  assign o_sleeping   = st.sleeping;
  assign o_wdt_clear  = st.wdt_clear;
  assign o_instr_done = st.done;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_done_gap: assert property (o_instr_done |=> !o_instr_done)
    else $error("instruction done on adjacent clocks");
  a_lit_one: assert property (exec_now && grp == mcu_exec_pkg::GRP_LIT
      && lop != mcu_exec_pkg::LIT_LITERAL_RETURN_OP |=> o_instr_done)
    else $error("literal instruction not one cycle");
  a_pc_write_two: assert property (exec_now &&
      grp == mcu_exec_pkg::GRP_REG && rop == mcu_exec_pkg::OP_MISC && dst &&
      r == mcu_exec_pkg::ADDR_PC |=> !o_instr_done &&
      o_pc[7:0] == $past(st.acc) ##1 !o_instr_done ##1 o_instr_done)
    else $error("program counter write not two cycles");
  a_jump_one: assert property (exec_now &&
      grp == mcu_exec_pkg::GRP_JMP |=> o_instr_done &&
      o_pc[9:0] == $past(k8) + 10'h000 + {$past(i_prog_data[9:8]), 8'h00})
    else $error("jump not one cycle or wrong target");
  a_skip_two: assert property (exec_now &&
      grp == mcu_exec_pkg::GRP_BIT && bop == mcu_exec_pkg::BOP_SKIP_SET &&
      rv[bnum] |=> !o_instr_done ##2
      (o_instr_done && o_pc == $past(st.pc, 3) + 13'h0002))
    else $error("true skip not two cycles");
  a_ioc_range: assert property ((~|st.ioc[4:0]) && (~|st.ioc[9:8]))
    else $error("missing control register written");
  a_bit_set_isr: assert property (exec_now &&
      grp == mcu_exec_pkg::GRP_BIT && bop == mcu_exec_pkg::BOP_SET &&
      r == mcu_exec_pkg::ADDR_INT_STATUS |=>
      $stable(st.regs[mcu_exec_pkg::ADDR_INT_STATUS]))
    else $error("bit set changed interrupt status");
  a_table_high: assert property (st.phase &&
      st.mode == mcu_exec_pkg::mode_table && st.tbl_dest[5:4] != 2'h0 |=>
      st.regs[$past(st.tbl_dest)] == ($past(st.tbl_high) ?
      $past(tbl_hi_bits) : $past(tbl_lo_bits)))
    else $error("table read stored wrong bits");
  a_long_target: assert property (st.phase &&
      st.mode == mcu_exec_pkg::mode_long |=>
      o_pc == $past(i_prog_data) && o_instr_done)
    else $error("long transfer target wrong");
  a_interrupt_return_op_top: assert property (exec_now &&
      grp == mcu_exec_pkg::GRP_REG && rop == mcu_exec_pkg::OP_MISC && !dst &&
      r == mcu_exec_pkg::MISC_INTERRUPT_RETURN_OP |=> o_pc == $past(top) && o_int_enable)
    else $error("interrupt return wrong");
  a_rotate_flags: assert property (exec_now &&
      grp == mcu_exec_pkg::GRP_REG && (rop == mcu_exec_pkg::OP_RRC ||
      rop == mcu_exec_pkg::OP_RLC) |=> $stable(o_zero) && $stable(o_dcarry))
    else $error("rotate changed zero or digit carry");

  c_skip: cover property (exec_now && goto_dead);
  c_long: cover property (st.mode == mcu_exec_pkg::mode_long && st.long_call);
  c_table: cover property (st.mode == mcu_exec_pkg::mode_table && st.tbl_high);
  c_sleep: cover property (o_sleeping ##1 !o_sleeping);
endmodule : mcu_instruction_executor
`default_nettype wire

// file: tb/prog_rom_model.sv
// Program memory model: answers with the word at the fetch address
`default_nettype none
module prog_rom_model (
  // Fetch port
  input  wire logic [12:0] i_addr,
  output logic      [12:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] words [0:8191];
  // Combinational read so the word is ready in the same clock as the address
  assign o_data = words[i_addr];
endmodule : prog_rom_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the instruction executor
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_srst, i_wake;
  logic [12:0] o_prog_addr, i_prog_data, o_pc;
  logic [7:0] o_acc;
  logic o_zero, o_carry, o_dcarry, o_int_enable, o_sleeping;
  logic o_wdt_clear, o_instr_done;
  int fail_count = 0;
  int checks = 0;
  int span;
  mcu_instruction_executor dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .o_prog_addr(o_prog_addr), .i_prog_data(i_prog_data), .i_wake(i_wake),
    .o_pc(o_pc), .o_acc(o_acc), .o_zero(o_zero), .o_carry(o_carry),
    .o_dcarry(o_dcarry), .o_int_enable(o_int_enable),
    .o_sleeping(o_sleeping), .o_wdt_clear(o_wdt_clear),
    .o_instr_done(o_instr_done));
  prog_rom_model rom (.i_addr(o_prog_addr), .o_data(i_prog_data));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [12:0] exp, got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic clear_rom;
    for (int i = 0; i < 8192; i++) rom.words[i] = 13'h0f00;
  endtask : clear_rom
  // Reset, run n instructions, span = clocks from first to last done
  task automatic run(input int n, output int sp);
    int seen, cyc, t1;
    seen = 0;
    cyc = 0;
    t1 = 0;
    i_srst = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_srst = 1'b0;
    while (seen < n && cyc < 200) begin
      @(negedge i_core_clk);
      cyc++;
      if (o_instr_done === 1'b1) begin
        seen++;
        if (seen == 1) t1 = cyc;
      end
    end
    sp = (seen == n) ? cyc - t1 : -1;
  endtask : run
  task automatic test_literal_flags;
    clear_rom();
    rom.words[0] = 13'h087f;
    rom.words[1] = 13'h0e81;
    run(3, span);
    chk("literal span", 13'h4, span[12:0]);
    chk("add result", 13'h0, {5'h0, o_acc});
    chk("add flags", 13'h7, {10'h0, o_zero, o_dcarry, o_carry});
  endtask : test_literal_flags
  task automatic test_pc_write;
    clear_rom();
    rom.words[0] = 13'h0805;
    rom.words[1] = 13'h0042;
    rom.words[5] = 13'h0833;
    run(3, span);
    chk("pc write span", 13'h6, span[12:0]);
    chk("pc write acc", 13'h33, {5'h0, o_acc});
  endtask : test_pc_write
  task automatic test_bit_skip;
    clear_rom();
    rom.words[0] = 13'h1220;
    rom.words[1] = 13'h1620;
    rom.words[2] = 13'h0899;
    rom.words[3] = 13'h0844;
    run(3, span);
    chk("skip span", 13'h6, span[12:0]);
    chk("skip acc", 13'h44, {5'h0, o_acc});
  endtask : test_bit_skip
  task automatic test_calls;
    clear_rom();
    rom.words[0] = 13'h0008;
    rom.words[1] = 13'h0100;
    rom.words[13'h100] = 13'h0c5a;
    rom.words[2] = 13'h1c10;
    rom.words[13'h10] = 13'h0002;
    run(4, span);
    chk("return span", 13'h6, span[12:0]);
    chk("literal return", 13'h5a, {5'h0, o_acc});
    chk("return pc", 13'h3, o_pc);
    chk("int enable", 13'h1, {12'h0, o_int_enable});
  endtask : test_calls
  task automatic test_refused;
    clear_rom();
    // Clears the whole register instead of single-bit clear
    rom.words[0] = 13'h08ff;
    rom.words[1] = 13'h014f;
    rom.words[2] = 13'h12cf;
    rom.words[3] = 13'h048f;
    rom.words[4] = 13'h083c;
    rom.words[5] = 13'h0088;
    run(4, span);
    chk("status set", 13'h0, {5'h0, o_acc});
    chk("move zero", 13'h1, {12'h0, o_zero});
    run(6, span);
    chk("bad ctrl read", 13'h3c, {5'h0, o_acc});
  endtask : test_refused
  task automatic test_table_ctrl;
    clear_rom();
    rom.words[0] = 13'h0840;
    rom.words[1] = 13'h0049;
    rom.words[2] = 13'h0880;
    rom.words[3] = 13'h004a;
    rom.words[4] = 13'h0120;
    rom.words[5] = 13'h04a0;
    rom.words[6] = 13'h00c5;
    rom.words[7] = 13'h0800;
    rom.words[8] = 13'h0085;
    rom.words[9] = 13'h06a0;
    rom.words[13'h40] = 13'h1b00;
    run(6, span);
    chk("table high acc", 13'h1b, {5'h0, o_acc});
    run(9, span);
    chk("ctrl read acc", 13'h1b, {5'h0, o_acc});
    run(10, span);
    chk("rotate acc", 13'h0d, {5'h0, o_acc});
    chk("rotate carry", 13'h1, {12'h0, o_carry});
    chk("rotate zero", 13'h0, {12'h0, o_zero});
  endtask : test_table_ctrl
  task automatic test_sleep;
    clear_rom();
    rom.words[0] = 13'h0005;
    rom.words[1] = 13'h0821;
    run(1, span);
    chk("sleep flag", 13'h1, {12'h0, o_sleeping});
    chk("sleep wdt", 13'h1, {12'h0, o_wdt_clear});
    chk("sleep fetch", 13'h1, o_prog_addr);
    repeat (6) @(negedge i_core_clk);
    chk("asleep acc", 13'h0, {5'h0, o_acc});
    i_wake = 1'b1;
    repeat (5) @(negedge i_core_clk);
    i_wake = 1'b0;
    chk("woken acc", 13'h21, {5'h0, o_acc});
    chk("woken flag", 13'h0, {12'h0, o_sleeping});
  endtask : test_sleep
  task automatic test_done;
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    i_srst = 1'b1;
    i_wake = 1'b0;
    test_literal_flags();
    test_pc_write();
    test_bit_skip();
    test_calls();
    test_refused();
    test_table_ctrl();
    test_sleep();
    test_done();
  end
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
